// [logic/fcp_cfg.svh]
// constants of the fifo configuration and port control block
`ifndef FCP_CFG_SVH
`define FCP_CFG_SVH
`define FCP_WORD_W 36
`define FCP_OFS_W 13
`define FCP_HALF_W 18
`define FCP_BYTE_W 9
`define FCP_SIZE_LONG 2'h0
`define FCP_SIZE_HALF 2'h1
`define FCP_SIZE_BYTE 2'h2
`define FCP_LAST_LONG 2'h0
`define FCP_LAST_HALF 2'h1
`define FCP_LAST_BYTE 2'h3
`define FCP_PRESET_64 13'h0040
`define FCP_PRESET_16 13'h0010
`define FCP_PRESET_8 13'h0008
`define FCP_PRESET_256 13'h0100
`define FCP_PRESET_1024 13'h0400
`define FCP_FS_64 3'h7
`define FCP_FS_16 3'h6
`define FCP_FS_8 3'h5
`define FCP_FS_256 3'h3
`define FCP_FS_1024 3'h1
`define FCP_FS_SERIAL 3'h2
`define FCP_FS_PAR 3'h4
`define FCP_FS_IP 3'h0
`define FCP_IP_SKIP_BIT 8
`define FCP_PAR_WRITES 2
`define FCP_DEPTH 2048
`endif

// [logic/fcp_fifo_ctrl.sv]
// fifo configuration, offset loading and port control
`timescale 1ns/100ps
`include "fcp_cfg.svh"
module fcp_fifo_ctrl
    import fcp_pkg::*;
#(
    parameter int DEPTH = `FCP_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // configuration pins
    input wire logic master_reset_n,
    input wire logic endian_timing_select,
    input wire logic [1:0] bus_size,
    input wire logic flag_sel2,
    input wire logic flag_sel1_serial_strobe_n,
    input wire logic flag_sel0_serial_in,
    // write port
    input wire logic port_a_select_n,
    input wire logic port_a_direction,
    input wire logic port_a_strobe,
    input wire logic port_a_mail_sel,
    input wire logic [`FCP_WORD_W-1:0] port_a_data_in,
    output logic [`FCP_WORD_W-1:0] port_a_data_out,
    output logic port_a_data_oe,
    // read port
    input wire logic port_b_select_n,
    input wire logic port_b_direction,
    input wire logic port_b_strobe,
    input wire logic port_b_mail_sel,
    output logic [`FCP_WORD_W-1:0] port_b_data_out,
    output logic port_b_data_oe,
    // flags
    output logic write_space_ready,
    output logic read_data_ready,
    output logic almost_empty_n,
    output logic near_full_n,
    output logic fall_through_mode
);
    localparam int OW = $clog2(DEPTH);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(2 * OW + 1);
    localparam int W = `FCP_WORD_W;
    localparam logic [CW-1:0] SER_BITS = CW'(2 * OW);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] pin_vec;
    logic [6:0] sync1_reg;
    logic [6:0] sync2_reg;
    logic msr_prev_reg;
    logic msr_s, et_s, fs2_s, fs1_s, fs0_s;
    logic [1:0] size_s;
    assign pin_vec = {master_reset_n, endian_timing_select, bus_size,
        flag_sel2, flag_sel1_serial_strobe_n, flag_sel0_serial_in};
    assign {msr_s, et_s, size_s, fs2_s, fs1_s, fs0_s} = sync2_reg;

    // two stages, then an edge memory for the master reset
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
            msr_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_vec;
            sync2_reg <= sync1_reg;
            msr_prev_reg <= sync2_reg[6];
        end
    end

    // ------------------------------------------------------------
    // configuration and offset loading
    // ------------------------------------------------------------
    fcp_state_t state_reg, state_next;
    fcp_prog_t prog_reg, prog_next;
    logic big_endian_reg, big_endian_next;
    logic fall_through_mode_reg, fall_through_mode_next;
    logic [1:0] size_reg, size_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [`FCP_OFS_W-1:0] x_reg, x_next, y_reg, y_next;
    logic [2*OW-1:0] sh_reg, sh_next;
    logic wr_req, wr_op, par_phase, wr_store, buf_in_ready;
    logic [`FCP_OFS_W-1:0] par_ofs;

    assign wr_req = !port_a_select_n && port_a_direction &&
        port_a_strobe && !port_a_mail_sel;
    assign wr_op = wr_req && write_space_ready;
    assign par_phase = (prog_reg == PM_PAR || prog_reg == PM_IP) &&
        cnt_reg < CW'(`FCP_PAR_WRITES);
    assign wr_store = wr_op && !par_phase;

    // offset field picked from the write data
    always_comb begin
        if (prog_reg == PM_IP) begin
            // skip bit 8 in parity mode
            par_ofs = `FCP_OFS_W'({port_a_data_in[OW:`FCP_IP_SKIP_BIT+1],
                port_a_data_in[`FCP_IP_SKIP_BIT-1:0]});
        end else begin
            // low bits, top bit most significant
            par_ofs = `FCP_OFS_W'(port_a_data_in[OW-1:0]);
        end
    end

    // next configuration state
    always_comb begin
        state_next = state_reg;
        prog_next = prog_reg;
        big_endian_next = big_endian_reg;
        fall_through_mode_next = fall_through_mode_reg;
        size_next = size_reg;
        cnt_next = cnt_reg;
        x_next = x_reg;
        y_next = y_reg;
        sh_next = sh_reg;
        if (!msr_s) begin
            state_next = ST_HOLD;
        end else begin
            case (state_reg)
                ST_HOLD: begin
                    if (!msr_prev_reg) begin
                        big_endian_next = et_s;
                        size_next = size_s;
                        cnt_next = '0;
                        state_next = ST_MODE;
                        prog_next = PM_PRESET;
                        case ({fs2_s, fs1_s, fs0_s})
                            `FCP_FS_64: x_next = `FCP_PRESET_64;
                            `FCP_FS_16: x_next = `FCP_PRESET_16;
                            `FCP_FS_8: x_next = `FCP_PRESET_8;
                            `FCP_FS_256: x_next = `FCP_PRESET_256;
                            `FCP_FS_1024: x_next = `FCP_PRESET_1024;
                            `FCP_FS_SERIAL: prog_next = PM_SERIAL;
                            `FCP_FS_PAR: prog_next = PM_PAR;
                            default: prog_next = PM_IP;
                        endcase
                        y_next = x_next;
                    end
                end
                ST_MODE: begin
                    fall_through_mode_next = !et_s;
                    state_next = (prog_reg == PM_SERIAL) ? ST_SERIAL : ST_RUN;
                end
                ST_SERIAL: begin
                    if (cnt_reg == SER_BITS) begin
                        // ready rises edge after last bit
                        y_next = `FCP_OFS_W'(sh_reg[2*OW-1:OW]);
                        x_next = `FCP_OFS_W'(sh_reg[OW-1:0]);
                        state_next = ST_RUN;
                    end else if (!fs1_s) begin
                        sh_next = {sh_reg[2*OW-2:0], fs0_s};
                        cnt_next = cnt_reg + CW'(1);
                    end
                end
                ST_RUN: begin
                    if (wr_op && par_phase) begin
                        if (cnt_reg == '0) begin
                            y_next = par_ofs;
                        end else begin
                            x_next = par_ofs;
                        end
                        cnt_next = cnt_reg + CW'(1);
                    end
                end
                default: state_next = ST_HOLD;
            endcase
        end
    end

    // configuration registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_reg <= ST_HOLD;
            prog_reg <= PM_PRESET;
            big_endian_reg <= 1'b0;
            fall_through_mode_reg <= 1'b0;
            size_reg <= `FCP_SIZE_LONG;
            cnt_reg <= '0;
            x_reg <= '0;
            y_reg <= '0;
            sh_reg <= '0;
        end else begin
            state_reg <= state_next;
            prog_reg <= prog_next;
            big_endian_reg <= big_endian_next;
            fall_through_mode_reg <= fall_through_mode_next;
            size_reg <= size_next;
            cnt_reg <= cnt_next;
            x_reg <= x_next;
            y_reg <= y_next;
            sh_reg <= sh_next;
        end
    end

    // ------------------------------------------------------------
    // data path: input buffer, memory, output register
    // ------------------------------------------------------------
    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] buf_reg [2];
    logic [W-1:0] buf_next [2];
    logic [1:0] buf_cnt_reg, buf_cnt_next;
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_mem_reg, cnt_mem_next;
    logic [W-1:0] out_reg, out_next, b_data_reg, b_data_next;
    logic out_valid_reg, out_valid_next;
    logic [1:0] piece_reg, piece_next, last_piece;
    logic rd_req, mem_ne, run, pop, fetch;

    assign run = state_reg == ST_RUN;
    assign mem_ne = cnt_mem_reg != '0;
    assign rd_req = !port_b_select_n && port_b_direction &&
        port_b_strobe && !port_b_mail_sel;
    assign buf_in_ready = buf_cnt_reg != 2'h2;
    // the buffer drains only while memory has room
    assign pop = buf_cnt_reg != 2'h0 && cnt_mem_reg < (AW+1)'(DEPTH);
    assign last_piece = size_reg == `FCP_SIZE_HALF ? `FCP_LAST_HALF :
        size_reg == `FCP_SIZE_BYTE ? `FCP_LAST_BYTE : `FCP_LAST_LONG;

    // piece of the output word shown on the read port
    function automatic logic [W-1:0] pick(input logic [W-1:0] word,
        input logic [1:0] piece, input logic [1:0] size,
        input logic [1:0] last, input logic big);
        logic [1:0] sel;
        sel = big ? last - piece : piece;
        case (size)
            `FCP_SIZE_HALF: pick = W'(word[`FCP_HALF_W*sel[0] +: `FCP_HALF_W]);
            `FCP_SIZE_BYTE: pick = W'(word[`FCP_BYTE_W*sel +: `FCP_BYTE_W]);
            default: pick = word;
        endcase
    endfunction : pick

    // next data path state
    always_comb begin
        fetch = 1'b0;
        buf_next = buf_reg;
        buf_cnt_next = buf_cnt_reg;
        wp_next = wp_reg;
        rp_next = rp_reg;
        out_next = out_reg;
        out_valid_next = out_valid_reg;
        piece_next = piece_reg;
        if (pop) begin
            buf_next[0] = buf_reg[1];
            buf_cnt_next = buf_cnt_reg - 2'h1;
            wp_next = wp_reg + AW'(1);
        end
        if (wr_store) begin
            buf_next[buf_cnt_next[0]] = port_a_data_in;
            buf_cnt_next = buf_cnt_next + 2'h1;
        end
        if (run && fall_through_mode_reg) begin
            if (!out_valid_reg) begin
                fetch = mem_ne;
            end else if (rd_req) begin
                if (piece_reg != last_piece) begin
                    piece_next = piece_reg + 2'h1;
                end else if (mem_ne) begin
                    fetch = 1'b1;
                end else begin
                    out_valid_next = 1'b0;
                end
            end
        end else if (run && rd_req && mem_ne) begin
            // standard moves word only on read
            if (out_valid_reg && piece_reg != last_piece) begin
                piece_next = piece_reg + 2'h1;
            end else begin
                fetch = 1'b1;
            end
        end
        if (fetch) begin
            out_next = mem[rp_reg];
            out_valid_next = 1'b1;
            piece_next = 2'h0;
            rp_next = rp_reg + AW'(1);
        end
        cnt_mem_next = cnt_mem_reg + (AW+1)'(pop) - (AW+1)'(fetch);
        if (!msr_s) begin
            buf_cnt_next = 2'h0;
            wp_next = '0;
            rp_next = '0;
            cnt_mem_next = '0;
            out_valid_next = 1'b0;
            piece_next = 2'h0;
        end
        b_data_next = pick(out_next, piece_next, size_reg, last_piece,
            big_endian_reg);
    end

    // data path registers
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            buf_reg <= '{default: '0};
            buf_cnt_reg <= 2'h0;
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_mem_reg <= '0;
            out_reg <= '0;
            out_valid_reg <= 1'b0;
            piece_reg <= 2'h0;
            b_data_reg <= '0;
        end else begin
            buf_reg <= buf_next;
            buf_cnt_reg <= buf_cnt_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_mem_reg <= cnt_mem_next;
            out_reg <= out_next;
            out_valid_reg <= out_valid_next;
            piece_reg <= piece_next;
            b_data_reg <= b_data_next;
        end
    end

    // storage array, written from the buffer head
    always_ff @(posedge clock) begin
        if (pop) begin
            mem[wp_reg] <= buf_reg[0];
        end
    end

    // ------------------------------------------------------------
    // pins and flags
    // ------------------------------------------------------------
    // write port drives when select and direction low
    assign port_a_data_oe = !port_a_select_n && !port_a_direction;
    assign port_a_data_out = '0;
    // read port drives when select low and direction high
    assign port_b_data_oe = !port_b_select_n && port_b_direction;
    assign port_b_data_out = b_data_reg;
    assign fall_through_mode = fall_through_mode_reg;
    assign write_space_ready = run && buf_in_ready;
    assign read_data_ready = run && (fall_through_mode_reg ? out_valid_reg : mem_ne);
    assign almost_empty_n = run && 14'(cnt_mem_reg) > {1'b0, x_reg};
    assign near_full_n = !run ||
        14'(cnt_mem_reg) < 14'(DEPTH) - {1'b0, y_reg};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_endian_latch: assert property (
        msr_s && !msr_prev_reg && state_reg == ST_HOLD
            |=> big_endian_reg == $past(et_s))
        else $error("endian not caught at reset rise");
    a_timing_mode: assert property (
        state_reg == ST_MODE && msr_s |=> fall_through_mode_reg == !$past(et_s))
        else $error("timing mode not caught after release");
    a_fall_first: assert property (
        run && fall_through_mode_reg && !out_valid_reg && mem_ne && msr_s
            |=> read_data_ready)
        else $error("first word did not fall through");
    a_std_hold: assert property (
        run && !fall_through_mode_reg && !rd_req && msr_s |=> $stable(out_reg))
        else $error("standard mode moved word without read");
    a_ready_delay: assert property (
        $rose(msr_s) && state_reg == ST_HOLD
            |-> !write_space_ready [*2])
        else $error("ready rose too early after reset");
    a_serial_hold: assert property (
        state_reg == ST_SERIAL |-> !write_space_ready)
        else $error("ready high during serial load");
    a_reset_flags: assert property (
        !msr_s |=> !write_space_ready && !read_data_ready &&
            !almost_empty_n && near_full_n)
        else $error("flags wrong during master reset");
    a_par_order: assert property (
        wr_op && par_phase && cnt_reg == '0 && msr_s
            |=> y_reg == $past(par_ofs) && $stable(buf_cnt_reg))
        else $error("first write did not load full offset");
    a_write_store: assert property (
        wr_store && msr_s |=> buf_cnt_reg != 2'h0)
        else $error("write not stored");
    a_read_refuse: assert property (
        run && !fall_through_mode_reg && rd_req && !mem_ne && msr_s |=> $stable(rp_reg))
        else $error("read taken from empty memory");
endmodule : fcp_fifo_ctrl

// [logic/fcp_pkg.sv]
// types of the fifo configuration and port control block
package fcp_pkg;
    // sequence after master reset
    typedef enum logic [3:0] {
        ST_HOLD = 4'h1,
        ST_MODE = 4'h2,
        ST_SERIAL = 4'h4,
        ST_RUN = 4'h8
    } fcp_state_t;
    // offset loading method latched at master reset
    typedef enum logic [3:0] {
        PM_PRESET = 4'h1,
        PM_SERIAL = 4'h2,
        PM_PAR = 4'h4,
        PM_IP = 4'h8
    } fcp_prog_t;
endpackage : fcp_pkg

// [tb/fcp_fifo_ctrl_tb.sv]
// self-checking bench of the fifo configuration and port control
`timescale 1ns/100ps
`include "fcp_cfg.svh"
module fcp_fifo_ctrl_tb;
    logic clock, reset_n, master_reset_n, endian_timing_select;
    logic [1:0] bus_size;
    logic flag_sel2, flag_sel1_serial_strobe_n, flag_sel0_serial_in;
    logic port_a_select_n, port_a_direction, port_a_strobe;
    logic port_a_mail_sel, port_a_data_oe, port_b_data_oe;
    logic [35:0] port_a_data_in, port_a_data_out, port_b_data_out, v, ob;
    logic port_b_select_n, port_b_direction, port_b_strobe;
    logic port_b_mail_sel, write_space_ready, read_data_ready;
    logic almost_empty_n, near_full_n, fall_through_mode;
    int error_cnt, total_checks;
    logic [35:0] dw [4] = '{36'h9_8765_4321, 36'h1_2345_6789,
        36'hA_5A5A_5A5A, 36'h5_A5A5_A5A5};
    // oe rows: a sel, a dir, b sel, b dir, a oe, b oe
    logic [5:0] oe_rows [4] = '{6'h02, 6'h15, 6'h28, 6'h3C};
    // design under test with a short memory
    fcp_fifo_ctrl #(.DEPTH(512)) uut (.clock, .reset_n, .master_reset_n,
        .endian_timing_select, .bus_size, .flag_sel2,
        .flag_sel1_serial_strobe_n, .flag_sel0_serial_in,
        .port_a_select_n, .port_a_direction, .port_a_strobe,
        .port_a_mail_sel, .port_a_data_in, .port_a_data_out,
        .port_a_data_oe, .port_b_select_n, .port_b_direction,
        .port_b_strobe, .port_b_mail_sel, .port_b_data_out,
        .port_b_data_oe, .write_space_ready, .read_data_ready,
        .almost_empty_n, .near_full_n, .fall_through_mode);
    // read-side controller
    fcp_host_model host (.clock, .port_b_select_n, .port_b_direction,
        .port_b_strobe, .port_b_mail_sel, .read_data_ready,
        .port_b_data_out);
    // compare and count
    task chk(input logic [35:0] seen, input logic [35:0] exp,
        input string what);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // wait edges, then step just past the edge
    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    // verdict and end of run
    task report_and_stop;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    // master reset with configuration pins held static
    task mres(input logic [2:0] fs, input logic e, input logic [1:0] sz);
        {flag_sel2, flag_sel1_serial_strobe_n, flag_sel0_serial_in} = fs;
        endian_timing_select = e; // level kept static
        bus_size = sz;
        master_reset_n = 1'b0;
        tick(6);
        chk(write_space_ready, 0, "ready in reset");
        chk(read_data_ready, 0, "data ready in reset");
        chk(almost_empty_n, 0, "almost empty in reset");
        chk(near_full_n, 1, "near full in reset");
        master_reset_n = 1'b1;
        tick(3);
        chk(write_space_ready, 0, "ready too early");
    endtask : mres
    // bounded wait for write room
    task wait_ws(input int lim);
        int n;
        n = 0;
        while (write_space_ready !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
        chk(write_space_ready, 1, "ready after reset");
    endtask : wait_ws
    // one write, strobe left high for back to back use
    task wr(input logic [35:0] d);
        int n;
        n = 0;
        port_a_data_in = d;
        port_a_strobe = 1'b1;
        while (write_space_ready !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        tick(1);
    endtask : wr
    // drop strobe and let counts settle
    task wr_done;
        port_a_strobe = 1'b0;
        tick(4);
    endtask : wr_done
    // clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // watchdog
    initial begin
        #400000;
        error_cnt++;
        report_and_stop();
    end
    // main sequence
    initial begin
        error_cnt = 0;
        total_checks = 0;
        reset_n = 1'b0;
        master_reset_n = 1'b0;
        endian_timing_select = 1'b1;
        bus_size = 2'h0;
        {flag_sel2, flag_sel1_serial_strobe_n, flag_sel0_serial_in} = 3'h7;
        {port_a_select_n, port_a_mail_sel, port_a_strobe} = 3'h0;
        port_a_direction = 1'b1;
        port_a_data_in = 36'h0_0000_0000;
        tick(16);
        reset_n = 1'b1;
        // parallel load, plain parity, standard timing, long word
        mres(3'h4, 1'b1, 2'h0); // parallel select
        wait_ws(8);
        chk(fall_through_mode, 0, "standard mode");
        for (int i = 0; i < 4; i++) begin
            {port_a_select_n, port_a_direction} = oe_rows[i][5:4];
            host.set_ctl(oe_rows[i][3], oe_rows[i][2]);
            tick(1);
            chk(port_a_data_oe, oe_rows[i][1], "write oe");
            chk(port_b_data_oe, oe_rows[i][0], "read oe");
            chk(port_a_data_out, 36'h0_0000_0000, "write port data");
        end
        {port_a_select_n, port_a_direction} = 2'h1;
        host.set_ctl(1'b0, 1'b1);
        ob = port_b_data_out;
        wr(36'h0_0000_01FC); // full offset 508, bit 8 used
        wr(36'h0_0000_0002); // empty offset of 2
        port_a_mail_sel = 1'b1;
        wr(36'hF_FFFF_FFFF);
        port_a_mail_sel = 1'b0;
        wr(dw[0]);
        wr(dw[1]);
        wr_done();
        chk(port_b_data_out, ob, "no read, no move");
        chk(read_data_ready, 1, "not empty");
        chk(almost_empty_n, 0, "two words");
        chk(near_full_n, 1, "two words");
        wr(dw[2]);
        wr(dw[3]);
        wr_done();
        chk(almost_empty_n, 1, "four words");
        chk(near_full_n, 0, "four words");
        for (int i = 0; i < 4; i++) begin
            host.rd(v);
            chk(v, dw[i], "long word read");
        end
        chk(read_data_ready, 0, "empty again");
        host.rd(v);
        chk(v, dw[3], "refused read keeps data");
        // interspersed parity: bit 8 ignored, bit 9 is offset bit 8
        mres(3'h0, 1'b1, 2'h0); // parity select
        wait_ws(8);
        wr(36'h0_0000_02FC); // full offset of 508
        wr(36'h0_0000_0102); // empty offset of 2
        for (int i = 0; i < 4; i++) begin
            wr(dw[i]);
        end
        wr_done();
        chk(almost_empty_n, 1, "parity four words");
        chk(near_full_n, 0, "parity four words");
        // preset of eight, fall-through, long word
        mres(3'h5, 1'b0, 2'h0); // preset select
        wait_ws(8);
        chk(fall_through_mode, 1, "fall-through mode");
        for (int i = 0; i < 9; i++) begin
            wr(36'h0_0000_1000 + 36'(i));
        end
        wr_done();
        chk(port_b_data_out, 36'h0_0000_1000, "fall-in word");
        chk(almost_empty_n, 0, "eight in memory");
        wr(36'h0_0000_2000);
        wr_done();
        chk(almost_empty_n, 1, "nine in memory");
        // little endian bytes, fall-through
        mres(3'h7, 1'b0, 2'h2);
        wait_ws(8);
        wr(dw[0]);
        wr_done();
        chk(read_data_ready, 1, "output ready");
        chk(port_b_data_out, {27'h0, dw[0][8:0]}, "first byte");
        for (int i = 1; i < 4; i++) begin
            host.rd(v);
            chk(v, {27'h0, dw[0][9*i+:9]}, "byte order");
        end
        host.rd(v);
        chk(read_data_ready, 0, "output drained");
        // big endian halves, standard
        mres(3'h7, 1'b1, 2'h1);
        wait_ws(8);
        wr(dw[1]);
        wr(dw[2]);
        wr_done();
        host.rd(v);
        chk(v, {18'h0, dw[1][35:18]}, "upper half first");
        host.rd(v);
        chk(v, {18'h0, dw[1][17:0]}, "lower half last");
        // presets of 16 and 256 seen through the almost-empty flag
        for (int r = 0; r < 2; r++) begin
            mres(r ? 3'h3 : 3'h6, 1'b1, 2'h0); // preset select
            wait_ws(8);
            for (int i = 0; i < (r ? 256 : 16); i++) begin
                wr(36'(i));
            end
            wr_done();
            chk(almost_empty_n, 0, "at preset");
            wr(36'h0_0000_0000);
            wr_done();
            chk(almost_empty_n, 1, "above preset");
        end
        // serial load of both offsets as one
        mres(3'h2, 1'b1, 2'h0); // serial select
        tick(2);
        for (int i = 0; i < 18; i++) begin
            flag_sel0_serial_in = (i == 8 || i == 17);
            flag_sel1_serial_strobe_n = 1'b0;
            tick(1);
        end
        flag_sel1_serial_strobe_n = 1'b1;
        chk(write_space_ready, 0, "held during shift");
        wait_ws(8);
        wr(dw[3]);
        wr_done();
        chk(almost_empty_n, 0, "one word");
        wr(dw[0]);
        wr_done();
        chk(almost_empty_n, 1, "two words serial");
        report_and_stop();
    end
endmodule : fcp_fifo_ctrl_tb

// [tb/fcp_host_model.sv]
// read-side controller model standing on the fifo read port
`timescale 1ns/100ps
`include "fcp_cfg.svh"
module fcp_host_model (
    // clock
    input wire logic clock,
    // read port controls
    output logic port_b_select_n,
    output logic port_b_direction,
    output logic port_b_strobe,
    output logic port_b_mail_sel,
    // read port status and data
    input wire logic read_data_ready,
    input wire logic [`FCP_WORD_W-1:0] port_b_data_out
);
    // idle: selected for reading, no strobe
    initial begin
        port_b_select_n = 1'b0;
        port_b_direction = 1'b1;
        port_b_strobe = 1'b0;
        port_b_mail_sel = 1'b0;
    end
    // chip select and direction set by the bench
    task set_ctl(input logic sel_n, input logic dir);
        port_b_select_n = sel_n;
        port_b_direction = dir;
    endtask : set_ctl
    task rd(output logic [`FCP_WORD_W-1:0] v);
        int n;
        n = 0;
        port_b_strobe = 1'b1;
        while (read_data_ready !== 1'b1 && n < 50) begin
            @(posedge clock);
            #1;
            n++;
        end
        @(posedge clock);
        #1;
        port_b_strobe = 1'b0;
        @(posedge clock);
        #1;
        v = port_b_data_out; // data stands until the next read
    endtask : rd
endmodule : fcp_host_model
